// ==== bench/flash_spi_frontend_chk.sv ====
// Port checks for the serial flash front end.
// Assumes a bind onto flash_spi_frontend with a short CYCLES.
`timescale 1ns/1ps
`default_nettype none
module flash_spi_frontend_chk
    import flash_spi_pkg::*;
#(
    parameter int CYCLES = CYCLE_COUNT
) (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic sck,
    input wire logic cs_n,
    input wire logic si,
    input wire logic so_o,
    input wire logic so_oe_n,
    input wire logic [7:0] tx_byte,
    input wire logic launch_cycle,
    input wire logic [7:0] rx_byte,
    input wire logic rx_valid,
    input wire logic rx_is_opcode,
    input wire logic [7:0] rx_index,
    input wire logic frame_end,
    input wire logic cycle_busy,
    input wire logic standby
);
    // ==========================================================
    // Busy length counter, so long cycles need no long repetition.
    logic [31:0] busy_cnt_q;
    logic [31:0] busy_cnt_d;
    always_comb begin
        busy_cnt_d = cycle_busy ? busy_cnt_q + 32'h1 : 32'h0;
    end
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            busy_cnt_q <= 32'h0;
        end else begin
            busy_cnt_q <= busy_cnt_d;
        end
    end
    // ==========================================================
    // Properties
    default clocking @(posedge mclk); endclocking
    default disable iff (!nrst);
    sequence idle_seq; cs_n [*8]; endsequence
    sequence close_seq; $rose(cs_n); endsequence
    chk_oe_tracks_cs: assert property (so_oe_n == cs_n)
        else $error("output enable differs from chip select");
    chk_quiet_deselect: assert property (idle_seq |-> !rx_valid)
        else $error("byte accepted while deselected");
    chk_frame_end_lag: assert property (close_seq |-> ##[2:4] frame_end)
        else $error("frame end pulse missing after deselect");
    chk_busy_no_standby: assert property (cycle_busy |-> !standby)
        else $error("standby while a cycle runs");
    chk_busy_from_end: assert property ($rose(cycle_busy) |->
        frame_end)
        else $error("cycle started outside a frame end");
    chk_busy_length: assert property ($fell(cycle_busy) |->
        busy_cnt_q >= CYCLES - 1 && busy_cnt_q <= CYCLES + 1)
        else $error("self timed cycle has wrong length");
    chk_standby_back: assert property ($fell(cycle_busy) && cs_n
        |-> ##[0:2] standby)
        else $error("standby not resumed after cycle");
    chk_rx_single: assert property (rx_valid |=> !rx_valid)
        else $error("receive strobe longer than one cycle");
    chk_opcode_first: assert property (rx_valid && rx_is_opcode
        |-> rx_index == 8'h00)
        else $error("opcode byte with nonzero index");
    chk_so_on_fall: assert property ($changed(so_o) && !cs_n
        && !$past(cs_n) |-> !sck)
        else $error("serial output moved while clock high");
endmodule
bind flash_spi_frontend flash_spi_frontend_chk #(.CYCLES(CYCLES)) chk_inst (
    .mclk(mclk), .nrst(nrst), .sck(sck), .cs_n(cs_n), .si(si), .so_o(so_o),
    .so_oe_n(so_oe_n), .tx_byte(tx_byte), .launch_cycle(launch_cycle),
    .rx_byte(rx_byte), .rx_valid(rx_valid), .rx_is_opcode(rx_is_opcode),
    .rx_index(rx_index), .frame_end(frame_end), .cycle_busy(cycle_busy),
    .standby(standby));
`default_nettype wire

// ==== bench/serial_flash_spi_frontend_bench.sv ====
// Self-checking bench for the serial flash front end.
// Assumes the host model and the bound checker beside the design.
`timescale 1ns/1ps
`default_nettype none
module serial_flash_spi_frontend_bench
    import flash_spi_pkg::*;
;
    typedef struct packed {logic cpol; logic [7:0] b0, b1, tx;} row_type;
    row_type rows [4] = '{{1'b0, 8'ha5, 8'h3c, 8'hc3},
        {1'b1, 8'h81, 8'h7e, 8'h5a}, {1'b0, 8'hff, 8'h00, 8'h96},
        {1'b1, 8'h01, 8'h80, 8'h69}};
    logic mclk = 1'b0;
    logic nrst = 1'b0;
    logic [7:0] tx_byte = 8'h00;
    logic launch_cycle = 1'b0;
    logic sck, cs_n, si, so_o, so_oe_n, rx_valid, rx_is_opcode;
    logic frame_end, cycle_busy, standby;
    logic [7:0] rx_byte, rx_index;
    logic [15:0] miso;
    logic [16:0] rxq [$];
    wire so_line;
    int mismatches = 0;
    int checks_done = 0;
    always #20 mclk = ~mclk;
    assign so_line = so_oe_n ? 1'bz : so_o;
    flash_spi_frontend #(.CYCLES(20)) dut (.mclk(mclk), .nrst(nrst),
        .sck(sck), .cs_n(cs_n), .si(si), .so_o(so_o), .so_oe_n(so_oe_n),
        .tx_byte(tx_byte), .launch_cycle(launch_cycle), .rx_byte(rx_byte),
        .rx_valid(rx_valid), .rx_is_opcode(rx_is_opcode),
        .rx_index(rx_index), .frame_end(frame_end),
        .cycle_busy(cycle_busy), .standby(standby));
    spi_host_model host (.sck(sck), .cs_n(cs_n), .si(si), .so(so_line));
    always @(posedge mclk) begin
        if (rx_valid === 1'b1) begin
            rxq.push_back({rx_is_opcode, rx_index, rx_byte});
        end
    end
    // ==========================================================
    // Shared helpers
    task automatic check(input logic [16:0] seen, input logic [16:0] exp);
        checks_done++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR at %0t: saw %h wanted %h", $time, seen, exp);
        end
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    initial begin
        #200000;
        mismatches++;
        close_out();
    end
    // ==========================================================
    // Tests
    initial begin
        repeat (3) @(posedge mclk);
        nrst <= 1'b1;
        repeat (2) @(posedge mclk);
        check(17'(standby), 17'h1);
        check(17'(so_oe_n), 17'h1);
        check(17'(so_line === 1'bz), 17'h1);
        check(17'(cycle_busy), 17'h0);
        host.noise();
        repeat (10) @(posedge mclk);
        check(17'(rxq.size()), 17'h0);
        $display("test done: reset and deselect");
        foreach (rows[i]) begin
            @(posedge mclk) tx_byte <= rows[i].tx;
            host.xfer(rows[i].cpol, {rows[i].b0, rows[i].b1}, 16, miso);
            repeat (10) @(posedge mclk);
            check(17'(rxq.size()), 17'h2);
            check(rxq[0], {9'h100, rows[i].b0});
            check(rxq[1], {9'h001, rows[i].b1});
            check(17'(miso), {1'b0, rows[i].tx, rows[i].tx});
            check(17'(standby), 17'h1);
            rxq.delete();
            $display("test done: row %0d", i);
        end
        // A 12 bit frame leaves four stray bits that must not leak on.
        host.xfer(1'b0, 16'hf0f0, 12, miso);
        host.xfer(1'b1, 16'h3300, 8, miso);
        repeat (10) @(posedge mclk);
        check(17'(rxq.size()), 17'h2);
        check(rxq[0], 17'h100f0);
        check(rxq[1], 17'h10033);
        $display("test done: partial byte");
        @(posedge mclk) launch_cycle <= 1'b1;
        host.xfer(1'b0, 16'h8200, 8, miso);
        @(posedge mclk) launch_cycle <= 1'b0;
        repeat (6) @(posedge mclk);
        check(17'(cycle_busy), 17'h1);
        check(17'(standby), 17'h0);
        for (int n = 0; n < 100 && cycle_busy !== 1'b0; n++) @(posedge mclk);
        repeat (3) @(posedge mclk);
        check(17'(cycle_busy), 17'h0);
        check(17'(standby), 17'h1);
        $display("test done: self timed cycle");
        close_out();
    end
endmodule
`default_nettype wire

// ==== bench/spi_host_model.sv ====
// Host side model: an SPI master in mode 0 or 3 with a 125 ns clock.
// Assumes the bench resolves the output line from its enable.
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
    output logic sck,
    output logic cs_n,
    output logic si,
    input wire logic so
);
    initial begin
        sck = 1'b0;
        cs_n = 1'b1;
        si = 1'b0;
    end
    // ==========================================================
    // One selected frame, bits most significant first.
    task automatic xfer(input logic cpol, input logic [15:0] mosi,
        input int nbits, output logic [15:0] miso);
        sck = cpol;
        #100 cs_n = 1'b0;
        miso = 16'h0000;
        for (int i = 0; i < nbits; i++) begin
            #62.5 sck = 1'b0;
            si = mosi[15 - i];
            #62.5 sck = 1'b1;
            miso = {miso[14:0], so};
        end
        #62.5 sck = cpol;
        #62.5 cs_n = 1'b1;
        si = ~si;
        #100;
    endtask
    // Clock and data toggling while deselected must be ignored.
    task automatic noise();
        for (int i = 0; i < 16; i++) begin
            #62.5 sck = ~sck;
            si = ~si;
        end
        sck = 1'b0;
    endtask
endmodule
`default_nettype wire

// ==== include/flash_spi_pkg.sv ====
// Constants shared by the serial flash front end.
// Assumes a core clock mclk at 25 MHz and a host-driven serial clock.
// ============================================================
// Operation
// [RULE_01] Deselected: serial output released to high impedance, device sits in standby.
// [RULE_02] Deselected: every serial input bit is ignored.
// [RULE_03] Chip select falling starts an operation, rising ends it.
// [RULE_04] After a program or erase launch, standby waits for completion.
// [RULE_05] Serial input sampled on every rising serial clock edge.
// [RULE_06] Serial output changes only on falling serial clock edges.
// [RULE_07] Works with SPI mode 0 and mode 3 hosts.
// [RULE_08] Program and erase cycles are timed internally without host clocking.
// [RULE_09] First byte after selection is an 8-bit opcode, then address.
// [RULE_10] All bytes travel most significant bit first.
// [RULE_11] Chip select rising discards partial bytes and resets counters; the byte index clears only on the next chip select fall.
package flash_spi_pkg;
    // ========================================================
    // Framing
    localparam int BYTE_BITS = 8;
    localparam logic [2:0] BIT_CNT_RESET = 3'h0;
    localparam logic [2:0] BIT_CNT_LAST = 3'h7;
    localparam logic [7:0] BYTE_CNT_RESET = 8'h00;
    // ========================================================
    // Timing
    localparam int CLK_HZ = 25000000;
    localparam int CYCLE_TIME_US = 1000;
    localparam int CYCLE_COUNT =
        (CLK_HZ / 1000000) * CYCLE_TIME_US;
    localparam int TIMER_BITS = 32;
    // ========================================================
    // Core states
    typedef enum logic [2:0] {
        ST_STANDBY = 3'b001,
        ST_ACTIVE = 3'b010,
        ST_BUSY = 3'b100
    } core_state_type;
endpackage

// ==== verilog/cycle_timer.sv ====
// Self-timed program or erase cycle counter on mclk.
// Assumes start is a one-cycle pulse from logic on mclk.
`timescale 1ns/1ps
`default_nettype none
module cycle_timer
    import flash_spi_pkg::*;
#(
    parameter int CYCLES = CYCLE_COUNT
) (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic start,
    output logic busy
);
    logic [TIMER_BITS-1:0] count_q, count_d;
    logic busy_q, busy_d;

    // ========================================================
    // Counter
    always_comb begin
        count_d = count_q;
        busy_d = busy_q;
        if (start && !busy_q) begin
            busy_d = 1'b1;
            count_d = TIMER_BITS'(CYCLES - 1);
        end else if (busy_q) begin
            if (count_q == '0) begin
                busy_d = 1'b0;
            end else begin
                count_d = count_q - 1'b1; // RULE_08
            end
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            count_q <= '0;
            busy_q <= 1'b0;
        end else begin
            count_q <= count_d;
            busy_q <= busy_d;
        end
    end

    assign busy = busy_q;
endmodule
`default_nettype wire

// ==== verilog/flash_spi_frontend.sv ====
// Serial front end: framing, shifting, output drive and standby hand-off.
// Assumes an SPI master in mode 0 or 3 driving sck, cs_n and si.
`timescale 1ns/1ps
`default_nettype none
module flash_spi_frontend
    import flash_spi_pkg::*;
#(
    parameter int CYCLES = CYCLE_COUNT
) (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic sck,
    input wire logic cs_n,
    input wire logic si,
    output logic so_o,
    output logic so_oe_n,
    input wire logic [7:0] tx_byte,
    input wire logic launch_cycle,
    output logic [7:0] rx_byte,
    output logic rx_valid,
    output logic rx_is_opcode,
    output logic [7:0] rx_index,
    output logic frame_end,
    output logic cycle_busy,
    output logic standby
);
    // ========================================================
    // Link side, clocked by sck. Async clear by cs_n high, except toggle and byte.
    logic [2:0] bit_cnt_q, bit_cnt_d;
    logic [6:0] shift_q, shift_d;
    logic [7:0] byte_q, byte_d;
    logic tog_q, tog_d;
    logic fell_q, fell_d;
    logic so_q, so_d;
    logic link_rst_n;

    // Deselection clears the link logic at once.
    assign link_rst_n = nrst && !cs_n; // RULE_11

    always_comb begin
        shift_d = {shift_q[5:0], si}; // RULE_05 RULE_10
        bit_cnt_d = bit_cnt_q + 3'h1;
        byte_d = byte_q;
        tog_d = tog_q;
        if (bit_cnt_q == BIT_CNT_LAST) begin
            byte_d = {shift_q, si}; // RULE_09
            tog_d = !tog_q;
        end
    end

    // Inputs are only taken while selected.
    always_ff @(posedge sck or negedge link_rst_n) begin
        if (!link_rst_n) begin
            bit_cnt_q <= BIT_CNT_RESET; // RULE_02 RULE_11
            shift_q <= '0;
        end else begin
            bit_cnt_q <= bit_cnt_d;
            shift_q <= shift_d;
        end
    end

    // Toggle and byte survive deselect, so the core still reads the last
    // byte of a frame after chip select has gone high.
    // While deselected the bit counter sits at zero, so both hold.
    always_ff @(posedge sck or negedge nrst) begin
        if (!nrst) begin
            tog_q <= 1'b0;
            byte_q <= '0;
        end else begin
            tog_q <= tog_d;
            byte_q <= byte_d;
        end
    end

    // The tx_byte input must stay stable for the whole byte.
    // Bit 7 stands from selection, which a mode 0 host needs before its
    // first rising edge; each falling edge then moves one bit on.
    always_comb begin
        so_d = tx_byte[BIT_CNT_LAST - bit_cnt_q]; // RULE_10
        fell_d = 1'b1;
    end

    // Falling edges only; with mode 3 the first falling edge repeats bit 7.
    always_ff @(negedge sck or negedge link_rst_n) begin
        if (!link_rst_n) begin
            fell_q <= 1'b0;
            so_q <= 1'b0;
        end else begin
            fell_q <= fell_d;
            so_q <= so_d; // RULE_06 RULE_07
        end
    end

    assign so_o = fell_q ? so_q : tx_byte[BIT_CNT_LAST]; // RULE_07
    assign so_oe_n = cs_n; // RULE_01

    // ========================================================
    // Core side crossings on mclk.
    logic cs_s1_q, cs_s2_q, cs_s3_q;
    logic cs_s1_d, cs_s2_d, cs_s3_d;
    logic tg_s1_q, tg_s2_q, tg_s3_q;
    logic tg_s1_d, tg_s2_d, tg_s3_d;
    logic [7:0] rx_byte_q, rx_byte_d;
    logic [7:0] idx_q, idx_d;
    logic rx_valid_q, rx_valid_d;
    logic frame_end_q, frame_end_d;
    logic opc_q, opc_d;
    logic cs_fall, cs_rise, byte_evt;

    // Two flip-flops settle each level; the third only feeds edge detection.
    always_comb begin
        cs_s1_d = cs_n;
        cs_s2_d = cs_s1_q;
        cs_s3_d = cs_s2_q;
        tg_s1_d = tog_q;
        tg_s2_d = tg_s1_q;
        tg_s3_d = tg_s2_q;
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            cs_s1_q <= 1'b1;
            cs_s2_q <= 1'b1;
            cs_s3_q <= 1'b1;
            tg_s1_q <= 1'b0;
            tg_s2_q <= 1'b0;
            tg_s3_q <= 1'b0;
        end else begin
            cs_s1_q <= cs_s1_d;
            cs_s2_q <= cs_s2_d;
            cs_s3_q <= cs_s3_d;
            tg_s1_q <= tg_s1_d;
            tg_s2_q <= tg_s2_d;
            tg_s3_q <= tg_s3_d;
        end
    end

    // Edge of a synchronised level, judged from its older and newer sample.
    function automatic logic level_edge(input logic older, input logic newer,
        input logic to_high);
        return (older != newer) && (newer == to_high);
    endfunction

    assign cs_fall = level_edge(cs_s3_q, cs_s2_q, 1'b0); // RULE_03
    assign cs_rise = level_edge(cs_s3_q, cs_s2_q, 1'b1); // RULE_03
    assign byte_evt = tg_s2_q != tg_s3_q;

    // The byte register is stable for a whole byte time after the toggle.
    always_comb begin
        rx_byte_d = rx_byte_q;
        idx_d = idx_q;
        opc_d = opc_q;
        rx_valid_d = 1'b0;
        frame_end_d = cs_rise;
        if (cs_fall) begin
            idx_d = BYTE_CNT_RESET; // RULE_11
        end
        if (byte_evt) begin
            rx_byte_d = byte_q;
            rx_valid_d = 1'b1;
            opc_d = (idx_q == BYTE_CNT_RESET); // RULE_09
            if (idx_q != 8'hff) begin
                idx_d = idx_q + 8'h01;
            end
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            rx_byte_q <= '0;
            idx_q <= BYTE_CNT_RESET;
            opc_q <= 1'b0;
            rx_valid_q <= 1'b0;
            frame_end_q <= 1'b0;
        end else begin
            rx_byte_q <= rx_byte_d;
            idx_q <= idx_d;
            opc_q <= opc_d;
            rx_valid_q <= rx_valid_d;
            frame_end_q <= frame_end_d;
        end
    end

    assign rx_byte = rx_byte_q;
    assign rx_valid = rx_valid_q;
    assign rx_is_opcode = opc_q;
    assign rx_index = idx_q - 8'h01;
    assign frame_end = frame_end_q;

    // ========================================================
    // Standby hand-off.
    logic launch_q, launch_d;
    logic start_pulse;
    core_state_type state_q, state_d;

    always_comb begin
        launch_d = launch_q;
        state_d = state_q;
        start_pulse = 1'b0;
        if (launch_cycle) begin
            launch_d = 1'b1;
        end
        unique case (state_q)
            ST_STANDBY: begin
                if (cs_fall) begin
                    state_d = ST_ACTIVE; // RULE_03
                end
            end
            ST_ACTIVE: begin
                if (cs_rise) begin
                    launch_d = 1'b0;
                    if (launch_q || launch_cycle) begin
                        start_pulse = 1'b1;
                        state_d = ST_BUSY; // RULE_04
                    end else begin
                        state_d = ST_STANDBY; // RULE_01
                    end
                end
            end
            ST_BUSY: begin
                launch_d = 1'b0;
                if (!cycle_busy && !start_pulse) begin
                    state_d = cs_s2_q ? ST_STANDBY : ST_ACTIVE; // RULE_04
                end
            end
            default: begin
                state_d = ST_STANDBY;
            end
        endcase
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            launch_q <= 1'b0;
            state_q <= ST_STANDBY;
        end else begin
            launch_q <= launch_d;
            state_q <= state_d;
        end
    end

    logic busy_seen_q, busy_seen_d;
    assign busy_seen_d = (state_q == ST_BUSY);
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            busy_seen_q <= 1'b0;
        end else begin
            busy_seen_q <= busy_seen_d;
        end
    end

    cycle_timer #(
        .CYCLES(CYCLES)
    ) u_timer (
        .mclk(mclk),
        .nrst(nrst),
        .start(start_pulse),
        .busy(cycle_busy)
    ); // RULE_08

    assign standby = (state_q == ST_STANDBY) && busy_seen_q == 1'b0;
endmodule
`default_nettype wire
